// [inc/psl_regs.svh]
// Offsets, field positions, reset values and timing counts for the strap
// latch. Holds definitions only and is included by its bare name.
`ifndef PSL_REGS_SVH
`define PSL_REGS_SVH

// Bus byte addresses of the three registers.
`define PSL_REG_CTRL 8'h00
`define PSL_REG_ADV 8'h04
`define PSL_REG_STAT 8'h08

// Basic control image fields.
`define PSL_CTRL_DUPLEX_BIT 8
`define PSL_CTRL_ISOLATE_BIT 10
`define PSL_CTRL_AUTONEG_BIT 12
`define PSL_CTRL_SPEED_BIT 13
`define PSL_CTRL_MASK 32'h0000_3500

// Advertisement image fields.
`define PSL_ADV_10_BIT 5
`define PSL_ADV_100_BIT 7
`define PSL_ADV_MASK 32'h0000_00a0

// Strap status fields.
`define PSL_STAT_ADDR_LSB 0
`define PSL_STAT_BCAST_BIT 5
`define PSL_STAT_MODE_LSB 6
`define PSL_STAT_NAND_BIT 9
`define PSL_STAT_DONE_BIT 10

// Strap codes and constants.
`define PSL_MODE_CODE_MII 3'h0
`define PSL_MODE_CODE_B2B 3'h6
`define PSL_ADDR_UPPER 2'h0
`define PSL_ADDR_BCAST 5'h00

// Level of every strap when only the internal pulls act.
`define PSL_STRAP_PULL 12'hf01

// Cycles from reset release before the captured value may be taken.
`define PSL_SETTLE_CYCLES 4'h3

`endif

// [inc/psl_pkg.sv]
// Types shared by the strap latch and its bench.
// Assumes psl_regs.svh sits in the include path.
package psl_pkg;

  // One bit for each strap pin, most significant first.
  typedef struct packed {
    logic nand_tree_n;
    logic autoneg_enable_strap;
    logic duplex;
    logic speed;
    logic isolate;
    logic [2:0] mode;
    logic broadcast_off_strap;
    logic mgmt_addr_strap_bit2;
    logic mgmt_addr_strap_bit1;
    logic mgmt_addr_strap_bit0;
  } psl_straps_t;

  typedef enum logic [1:0] {
    PSL_MODE_MII,
    PSL_MODE_B2B,
    PSL_MODE_RSVD
  } psl_mode_t;

  // Configuration that the rest of the transceiver uses.
  typedef struct packed {
    logic [4:0] phy_addr;
    logic bcast_en;
    psl_mode_t mode;
    logic isolate;
    logic speed_100;
    logic half_duplex;
    logic autoneg_en;
    logic adv_100;
    logic adv_10;
    logic nand_tree_en;
    logic captured;
  } psl_cfg_t;

  typedef enum logic {
    PSL_ST_HOLD,
    PSL_ST_RUN
  } psl_state_t;

endpackage

// [verilog/psl_strap_latch.sv]
// Strap latch: captures the configuration straps after chip reset and
// keeps the resulting configuration, with an AHB-Lite register port.
// Assumes one 25 MHz clock, pins outside its domain and a single master.
//
// Summary of operation
// [R1] After reset release the three address straps become the low bits of the management address, any value 0 to 7.
// [R2] With no board strapping the pulls give management address 00001.
// [R3] The upper two management address bits are always zero.
// [R4] Address 00000 is a unique own address only if the broadcast-off strap was high.
// [R5] With the broadcast-off strap low, address zero is a broadcast answered besides the own address.
// [R6] Interface mode code 000 is normal MII, 110 is back-to-back, all others reserved.
// [R7] The isolate strap sets control bit 10, high meaning isolated.
// [R8] The speed strap sets control bit 13 and the speed advertisement, high meaning 100 Mbps.
// [R9] The duplex strap sets control bit 8, high meaning half duplex.
// [R10] The auto-negotiation strap sets control bit 12, high meaning enabled.
// [R11] A low NAND-tree strap enables NAND-tree test mode.
// [R12] Strap pins are inputs during reset and turn to outputs after release.
// [R13] Attached logic must not drive the strap pins during power-up or reset.
// [R14] Captured values hold until the next reset; software may rewrite control bits.
//
// Implementation choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_strap_latch (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire psl_pkg::psl_straps_t strap_pin_in,
  output psl_pkg::psl_straps_t strap_pin_out,
  output psl_pkg::psl_straps_t strap_pin_oe,
  input wire psl_pkg::psl_straps_t func_out,
  input wire logic mgmt_query_valid,
  input wire logic [4:0] mgmt_query_addr,
  output logic mgmt_addr_hit,
  output psl_pkg::psl_cfg_t cfg,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);
  import psl_pkg::*;

  // Pin synchronisers carry no reset so that the pins are sampled while
  // the chip reset is still low; every other register is reset.
  psl_straps_t sync1;
  psl_straps_t sync2;
  psl_straps_t sync3;
  psl_straps_t next_sync1;
  psl_straps_t next_sync2;
  psl_straps_t next_sync3;

  // Only the second stage reads the first, so a metastable first stage
  // never reaches the capture or the stability compare.
  always_comb begin
    next_sync1 = strap_pin_in;
    next_sync2 = sync1;
    next_sync3 = sync2;
  end

  always_ff @(posedge core_clk) begin
    sync1 <= next_sync1;
    sync2 <= next_sync2;
    sync3 <= next_sync3;
  end

  // Capture sequence.
  psl_state_t state;
  psl_state_t next_state;
  logic [3:0] settle;
  logic [3:0] next_settle;
  logic stable;
  logic capture;

  // A level counts only once the second and third stages agree.
  assign stable = (sync2 == sync3);
  assign capture = (state == PSL_ST_HOLD) && (settle == `PSL_SETTLE_CYCLES)
                   && stable;

  always_comb begin
    next_state = state;
    next_settle = settle;
    case (state)
      PSL_ST_HOLD: begin
        if (settle != `PSL_SETTLE_CYCLES) begin
          next_settle = settle + 4'h1;
        end
        if (capture) begin
          next_state = PSL_ST_RUN;
        end
      end
      PSL_ST_RUN: begin
        next_state = PSL_ST_RUN; // see [R14]
      end
      default: begin
        next_state = PSL_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= PSL_ST_HOLD;
      settle <= 4'h0;
    end else begin
      state <= next_state;
      settle <= next_settle;
    end
  end

  // Captured strap image; it starts at the pulled levels and changes only
  // at the capture, so it reads the same until the next reset.
  psl_straps_t straps;
  psl_straps_t next_straps;

  always_comb begin
    next_straps = straps;
    if (capture) begin
      next_straps = sync3; // see [R1]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      straps <= psl_straps_t'(`PSL_STRAP_PULL); // see [R2]
    end else begin
      straps <= next_straps;
    end
  end

  // Pin direction: input with pull until capture, output afterwards.
  psl_straps_t next_pin_out;
  psl_straps_t next_pin_oe;

  always_comb begin
    next_pin_out = '0;
    next_pin_oe = '0; // see [R12]
    if (state == PSL_ST_RUN) begin
      next_pin_out = func_out;
      next_pin_oe = '1; // see [R12]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_pin_out <= '0;
      strap_pin_oe <= '0;
    end else begin
      strap_pin_out <= next_pin_out;
      strap_pin_oe <= next_pin_oe;
    end
  end

  // AHB-Lite slave. Every transfer completes with no wait state, so the
  // read word is prepared in the address phase.
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic ahb_go;
  logic [31:0] ctrl_word;
  logic [31:0] adv_word;
  logic [31:0] stat_word;

  assign ahb_go = hsel && htrans[1] && hready;

  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[`PSL_CTRL_DUPLEX_BIT] = cfg.half_duplex;
    ctrl_word[`PSL_CTRL_ISOLATE_BIT] = cfg.isolate;
    ctrl_word[`PSL_CTRL_AUTONEG_BIT] = cfg.autoneg_en;
    ctrl_word[`PSL_CTRL_SPEED_BIT] = cfg.speed_100;
    adv_word = 32'h0000_0000;
    adv_word[`PSL_ADV_10_BIT] = cfg.adv_10;
    adv_word[`PSL_ADV_100_BIT] = cfg.adv_100;
    stat_word = 32'h0000_0000;
    stat_word[`PSL_STAT_ADDR_LSB +: 5] = cfg.phy_addr;
    stat_word[`PSL_STAT_BCAST_BIT] = straps.broadcast_off_strap;
    stat_word[`PSL_STAT_MODE_LSB +: 3] = straps.mode;
    stat_word[`PSL_STAT_NAND_BIT] = cfg.nand_tree_en;
    stat_word[`PSL_STAT_DONE_BIT] = cfg.captured;
  end

  always_comb begin
    next_wr_pend = 1'b0;
    next_wr_addr = wr_addr;
    next_hrdata = 32'h0000_0000;
    if (ahb_go) begin
      next_wr_pend = hwrite;
      next_wr_addr = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          `PSL_REG_CTRL: next_hrdata = ctrl_word;
          `PSL_REG_ADV: next_hrdata = adv_word;
          `PSL_REG_STAT: next_hrdata = stat_word;
          default: next_hrdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Configuration outputs. The capture takes priority over a software
  // write in the same cycle, and writes before capture are dropped so the
  // straps cannot be overtaken by an early write.
  psl_cfg_t next_cfg;
  logic sw_ctrl;
  logic sw_adv;

  assign sw_ctrl = wr_pend && (wr_addr == `PSL_REG_CTRL)
                   && (state == PSL_ST_RUN);
  assign sw_adv = wr_pend && (wr_addr == `PSL_REG_ADV)
                  && (state == PSL_ST_RUN);

  always_comb begin
    next_cfg = cfg;
    if (capture) begin
      next_cfg.phy_addr = {`PSL_ADDR_UPPER, sync3.mgmt_addr_strap_bit2,
                           sync3.mgmt_addr_strap_bit1,
                           sync3.mgmt_addr_strap_bit0}; // see [R1] see [R3]
      next_cfg.bcast_en = !sync3.broadcast_off_strap; // see [R5]
      case (sync3.mode)
        `PSL_MODE_CODE_MII: next_cfg.mode = PSL_MODE_MII; // see [R6]
        `PSL_MODE_CODE_B2B: next_cfg.mode = PSL_MODE_B2B; // see [R6]
        default: next_cfg.mode = PSL_MODE_RSVD; // see [R6]
      endcase
      next_cfg.isolate = sync3.isolate; // see [R7]
      next_cfg.speed_100 = sync3.speed; // see [R8]
      next_cfg.adv_100 = sync3.speed; // see [R8]
      next_cfg.adv_10 = 1'b1;
      next_cfg.half_duplex = sync3.duplex; // see [R9]
      next_cfg.autoneg_en = sync3.autoneg_enable_strap; // see [R10]
      next_cfg.nand_tree_en = !sync3.nand_tree_n; // see [R11]
      next_cfg.captured = 1'b1;
    end else if (sw_ctrl) begin
      next_cfg.half_duplex = hwdata[`PSL_CTRL_DUPLEX_BIT]; // see [R14]
      next_cfg.isolate = hwdata[`PSL_CTRL_ISOLATE_BIT]; // see [R14]
      next_cfg.autoneg_en = hwdata[`PSL_CTRL_AUTONEG_BIT]; // see [R14]
      next_cfg.speed_100 = hwdata[`PSL_CTRL_SPEED_BIT]; // see [R14]
    end else if (sw_adv) begin
      next_cfg.adv_10 = hwdata[`PSL_ADV_10_BIT]; // see [R14]
      next_cfg.adv_100 = hwdata[`PSL_ADV_100_BIT]; // see [R14]
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg.phy_addr <= {`PSL_ADDR_UPPER, 3'h1}; // see [R2]
      cfg.bcast_en <= 1'b1;
      cfg.mode <= PSL_MODE_MII;
      cfg.isolate <= 1'b0;
      cfg.speed_100 <= 1'b1;
      cfg.half_duplex <= 1'b1;
      cfg.autoneg_en <= 1'b1;
      cfg.adv_100 <= 1'b1;
      cfg.adv_10 <= 1'b1;
      cfg.nand_tree_en <= 1'b0;
      cfg.captured <= 1'b0;
    end else begin
      cfg <= next_cfg;
    end
  end

  // Management address match, answered one cycle after the query. Address
  // zero matches through equality when it is the strapped unique address.
  logic next_hit;

  always_comb begin
    next_hit = 1'b0;
    if (mgmt_query_valid && cfg.captured) begin
      if (mgmt_query_addr == cfg.phy_addr) begin
        next_hit = 1'b1; // see [R1] see [R4]
      end else if (mgmt_query_addr == `PSL_ADDR_BCAST && cfg.bcast_en) begin
        next_hit = 1'b1; // see [R5]
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_addr_hit <= 1'b0;
    end else begin
      mgmt_addr_hit <= next_hit;
    end
  end

endmodule // psl_strap_latch

// [tb/psl_board_model.sv]
// Board side of the strap pins: pull resistors, board straps, device drive.
// Assumes the device's output enables are high while it drives a pin.
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_board_model (
  input wire psl_pkg::psl_straps_t strap_pin_out,
  input wire psl_pkg::psl_straps_t strap_pin_oe,
  input wire psl_pkg::psl_straps_t board_drv,
  input wire psl_pkg::psl_straps_t board_val,
  output psl_pkg::psl_straps_t pin_level
);
  import psl_pkg::*;
  // Only the board resistors act during reset; no MAC drives the pins.
  // A pin that neither side drives falls back to its internal pull.
  assign pin_level = (strap_pin_oe & strap_pin_out)
    | (~strap_pin_oe & ((board_drv & board_val)
    | (~board_drv & psl_straps_t'(`PSL_STRAP_PULL))));
endmodule // psl_board_model

// [tb/psl_strap_latch_chk.sv]
// Concurrent checks on the strap latch ports.
// Assumes pins stay stable from reset assertion until after capture.
`timescale 1ns/1ps

module psl_strap_latch_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire psl_pkg::psl_straps_t strap_pin_in,
  input wire psl_pkg::psl_straps_t strap_pin_oe,
  input wire logic mgmt_query_valid,
  input wire logic [4:0] mgmt_query_addr,
  input wire logic mgmt_addr_hit,
  input wire psl_pkg::psl_cfg_t cfg
);
  import psl_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_upper;
    cfg.phy_addr[4:3] == 2'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper address bits set");
  property p_bound;
    $rose(reset_n) |-> ##[1:6] cfg.captured;
  endproperty
  a_bound: assert property (p_bound)
    else $error("no capture after reset");
  property p_addr;
    $rose(cfg.captured) |-> cfg.phy_addr[2:0] == strap_pin_in[2:0]
      && cfg.bcast_en == !strap_pin_in.broadcast_off_strap
      && cfg.nand_tree_en == !strap_pin_in.nand_tree_n;
  endproperty
  a_addr: assert property (p_addr)
    else $error("address straps captured wrongly");
  property p_ctrl;
    $rose(cfg.captured) |-> cfg.isolate == strap_pin_in.isolate
      && cfg.speed_100 == strap_pin_in.speed
      && cfg.adv_100 == strap_pin_in.speed
      && cfg.half_duplex == strap_pin_in.duplex
      && cfg.autoneg_en == strap_pin_in.autoneg_enable_strap;
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control straps captured wrongly");
  property p_mode;
    $rose(cfg.captured) |-> cfg.mode == ((strap_pin_in.mode == 3'h0) ?
      PSL_MODE_MII : (strap_pin_in.mode == 3'h6) ? PSL_MODE_B2B
      : PSL_MODE_RSVD);
  endproperty
  a_mode: assert property (p_mode)
    else $error("mode captured wrongly");
  property p_oe;
    (strap_pin_oe != 12'h000 |-> cfg.captured)
      and ($rose(cfg.captured) |=> strap_pin_oe == 12'hfff);
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin direction wrong");
  property p_hold;
    cfg.captured && $past(cfg.captured) |-> $stable(cfg.phy_addr)
      && $stable(cfg.bcast_en) && $stable(cfg.mode);
  endproperty
  a_hold: assert property (p_hold)
    else $error("captured value changed");
  property p_hit;
    mgmt_query_valid && cfg.captured && (mgmt_query_addr == cfg.phy_addr
      || (mgmt_query_addr == 5'h00 && cfg.bcast_en)) |=> mgmt_addr_hit;
  endproperty
  a_hit: assert property (p_hit)
    else $error("query not answered");
  property p_miss;
    mgmt_query_valid && cfg.captured && mgmt_query_addr != cfg.phy_addr
      && !(mgmt_query_addr == 5'h00 && cfg.bcast_en) |=> !mgmt_addr_hit;
  endproperty
  a_miss: assert property (p_miss)
    else $error("foreign query answered");
endmodule // psl_strap_latch_chk

bind psl_strap_latch psl_strap_latch_chk i_psl_strap_latch_chk (.core_clk,
  .reset_n, .strap_pin_in, .strap_pin_oe, .mgmt_query_valid,
  .mgmt_query_addr, .mgmt_addr_hit, .cfg);

// [tb/psl_strap_latch_tb.sv]
// Bench for the strap latch: strap sets, register reads and address queries.
// Assumes the board model sits on the pins and hready follows hreadyout.
`timescale 1ns/1ps
`include "psl_regs.svh"

module psl_strap_latch_tb;
  import psl_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  psl_straps_t strap_pin_in, strap_pin_out, strap_pin_oe;
  psl_straps_t func_out = '0;
  psl_straps_t drv = '0;
  psl_straps_t val = '0;
  logic mgmt_query_valid = 1'b0;
  logic [4:0] mgmt_query_addr = 5'h00;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, st;
  logic mgmt_addr_hit, hready, hresp;
  psl_cfg_t cfg;
  int failures = 0;
  int samples_checked = 0;
  logic [11:0] s;
  logic [4:0] own;

  always #20 core_clk = ~core_clk;

  psl_strap_latch i_psl_strap_latch (.core_clk, .reset_n, .strap_pin_in,
    .strap_pin_out, .strap_pin_oe, .func_out, .mgmt_query_valid,
    .mgmt_query_addr, .mgmt_addr_hit, .cfg, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout(hready), .hrdata, .hresp);
  psl_board_model i_psl_board_model (.strap_pin_out, .strap_pin_oe,
    .board_drv(drv), .board_val(val), .pin_level(strap_pin_in));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Hready and read data are taken at the rising edge that closes each
  // phase, before the slave's registers move on that edge.
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, rd);
    chk(rd, e);
  endtask

  task automatic query(input logic [4:0] a, input logic e);
    mgmt_query_valid <= 1'b1;
    mgmt_query_addr <= a;
    @(posedge core_clk);
    mgmt_query_valid <= 1'b0;
    @(negedge core_clk);
    chk(32'(mgmt_addr_hit), 32'(e));
    @(posedge core_clk);
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge core_clk);
    failures++;
    end_sim();
  end

  // Set 0 leaves the pins to the pulls; sets 1 to 8 walk all mode codes.
  // A write and a query before capture must both be ignored.
  initial begin
    for (int i = 0; i < 9; i++) begin
      s = (i == 0) ? `PSL_STRAP_PULL
        : {4'(i * 7), i[1], 3'(i - 1), i[3] | i[0], 3'(8 - i)};
      own = {2'h0, s[2:0]};
      st = {21'h0, 1'b1, ~s[11], s[6:4], s[3], own};
      drv <= (i == 0) ? 12'h000 : 12'hfff;
      val <= s;
      reset_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      ahb(1'b1, `PSL_REG_CTRL, 32'hffff_ffff, rd);
      query(own, 1'b0);
      repeat (4) @(posedge core_clk);
      chk(32'(strap_pin_oe), 32'hfff);
      chk(32'(cfg.phy_addr), 32'(own));
      chk(32'(cfg.bcast_en), {31'h0, ~s[3]});
      chk(32'(cfg.mode), (s[6:4] == 3'h0) ? 32'(PSL_MODE_MII)
        : (s[6:4] == 3'h6) ? 32'(PSL_MODE_B2B) : 32'(PSL_MODE_RSVD));
      rd_chk(`PSL_REG_STAT, st);
      rd_chk(`PSL_REG_CTRL,
        {18'h0, s[8], s[10], 1'b0, s[7], 1'b0, s[9], 8'h0});
      rd_chk(`PSL_REG_ADV, {24'h0, s[8], 1'b0, 1'b1, 5'h0});
      query(own, 1'b1);
      query(5'h00, (own == 5'h00) | ~s[3]);
      query(own ^ 5'h03, (own == 5'h03) & ~s[3]);
      func_out <= ~s;
      ahb(1'b1, `PSL_REG_CTRL, 32'h0, rd);
      ahb(1'b1, `PSL_REG_ADV, 32'h0, rd);
      ahb(1'b1, `PSL_REG_STAT, 32'h0, rd);
      rd_chk(`PSL_REG_CTRL, 32'h0);
      rd_chk(`PSL_REG_ADV, 32'h0);
      rd_chk(`PSL_REG_STAT, st);
      ahb(1'b1, `PSL_REG_CTRL, 32'hffff_ffff, rd);
      rd_chk(`PSL_REG_CTRL, `PSL_CTRL_MASK);
      rd_chk(8'h0c, 32'h0);
      chk(32'(strap_pin_out), {20'h0, ~s});
      chk(32'(cfg.phy_addr), 32'(own));
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule // psl_strap_latch_tb
